// [pkg/video_loop_pkg.sv]
// Constants and types for the video loop lock controller
package video_loop_pkg;

	// Register byte addresses
	localparam logic [11:0] TRIGGER_ONE_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ONE_ADDR = 12'h004;
	localparam logic [11:0] TRIGGER_TWO_ADDR = 12'h008;
	localparam logic [11:0] STATUS_TWO_ADDR = 12'h00C;
	localparam logic [11:0] ATTEMPTS_ADDR = 12'h010;

	// Field positions
	localparam int GO_BIT = 0;
	localparam int BUSY_BIT = 0;
	localparam int BYPASS_BIT = 6;
	localparam int JITTER_BIT = 5;
	localparam int REF_LOST_BIT = 3;
	localparam int RECAL_BIT = 2;
	localparam int LOCK_BIT = 1;
	localparam int RESET_DONE_BIT = 0;
	localparam int ATTEMPT_TWO_LSB = 8;
	localparam int STATUS_W = 7;
	localparam int ATTEMPT_W = 5;
	localparam int NUM_LOOPS = 2;

	// Reset values
	localparam logic [31:0] READ_RESET = 32'h0000_0000;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 7'h00;
	localparam logic [ATTEMPT_W-1:0] ATTEMPT_RESET = 5'h00;
	localparam logic [ATTEMPT_W-1:0] ATTEMPT_MAX = 5'h1F;

	// Restart pulse to the analog loop
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESTART_NS = 80;
	localparam logic [2:0] RESTART_CYCLES =
		3'((RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RESTART,
		SEQ_SETTLE
	} seq_state_type;

endpackage : video_loop_pkg

// [src/flag_sync.sv]
// Two-stage synchroniser for asynchronous loop flags
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Flags
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] first_reg;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			first_reg <= '0;
			sync_o <= '0;
		end
		else
		begin
			first_reg <= async_i;
			sync_o <= first_reg;
		end
	end

endmodule : flag_sync
`default_nettype wire

// [src/loop_sequencer.sv]
// Lock sequence control for one video loop
`timescale 1ns/1ps
`default_nettype none
module loop_sequencer (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Control
	input wire logic go_i,
	input wire logic locked_i,
	// Results
	output logic restart_o,
	output logic busy_o,
	output logic [video_loop_pkg::ATTEMPT_W-1:0] attempts_o
);

	video_loop_pkg::seq_state_type state_reg;
	logic [2:0] count_reg;

	// A new go always restarts, even mid-sequence, so a retry after a
	// failed attempt gets a fresh restart pulse
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= video_loop_pkg::SEQ_IDLE;
			count_reg <= 3'h0;
		end
		else if (go_i)
		begin
			state_reg <= video_loop_pkg::SEQ_RESTART;
			count_reg <= video_loop_pkg::RESTART_CYCLES - 3'h1;
		end
		else
		begin
			case (state_reg)
				video_loop_pkg::SEQ_RESTART:
				begin
					if (count_reg == 3'h0)
						state_reg <= video_loop_pkg::SEQ_SETTLE;
					else
						count_reg <= count_reg - 3'h1;
				end
				video_loop_pkg::SEQ_SETTLE:
				begin
					if (locked_i)
						state_reg <= video_loop_pkg::SEQ_IDLE;
				end
				default:
					state_reg <= video_loop_pkg::SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			restart_o <= 1'b0;
		else
			restart_o <= go_i ||
				(state_reg == video_loop_pkg::SEQ_RESTART &&
				count_reg != 3'h0 && !go_i);
	end

	// Saturates so software can see a retry storm
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			attempts_o <= video_loop_pkg::ATTEMPT_RESET;
		else if (go_i && attempts_o != video_loop_pkg::ATTEMPT_MAX)
			attempts_o <= attempts_o + 5'h01;
	end

	assign busy_o = (state_reg != video_loop_pkg::SEQ_IDLE);

	AST_GO_RESTARTS: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		go_i |=> restart_o [*4])
		else $error("Go did not give a four-cycle restart");

	AST_RETRY_RELOCKS: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		go_i && busy_o |=> state_reg == video_loop_pkg::SEQ_RESTART
		##4 state_reg != video_loop_pkg::SEQ_RESTART || $past(go_i, 4)
		|| $past(go_i, 3) || $past(go_i, 2) || $past(go_i, 1))
		else $error("Retry did not restart the lock sequence");

endmodule : loop_sequencer
`default_nettype wire

// [src/video_loop_lock_ctrl.sv]
// APB lock control and status for the two video loops
// Summary of operation
// - A later lock attempt must be possible; each go restarts the loop.
// - Writing one to go bit 0 starts a lock sequence.
// - Status bit 6 reads 0 when the loop output is not bypassed.
// - Status bit 5 reads 1 on excess jitter, 0 when clean.
// - Status bit 3 flags loss of reference input.
// - Status bit 2 flags recalibration needed or in progress.
// - Status bit 1 reads 1 once lock is achieved, else 0.
// - Status bit 0 reads 1 once controller reset is complete.
`timescale 1ns/1ps
`default_nettype none
module video_loop_lock_ctrl (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// APB slave
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Flags from the analog loops, index 0 is loop one
	input wire logic [1:0] loop_locked_i,
	input wire logic [1:0] loop_bypassed_i,
	input wire logic [1:0] excess_jitter_flag_i,
	input wire logic [1:0] reference_lost_flag_i,
	input wire logic [1:0] recalibration_flag_i,
	input wire logic [1:0] controller_reset_complete_i,
	// Restart request to the analog loops
	output logic [1:0] loop_restart_o
);

	localparam int N = video_loop_pkg::NUM_LOOPS;

	logic [N-1:0] locked_s;
	logic [N-1:0] bypass_s;
	logic [N-1:0] jitter_s;
	logic [N-1:0] ref_lost_s;
	logic [N-1:0] recal_s;
	logic [N-1:0] reset_done_s;
	logic [N-1:0] go_pulse;
	logic [N-1:0] busy;
	logic [N-1:0] restart;
	logic [video_loop_pkg::ATTEMPT_W-1:0] attempts [N];
	logic [video_loop_pkg::STATUS_W-1:0] status_reg [N];
	logic [11:0] trigger_addr [N];
	logic [11:0] status_addr [N];
	logic access;
	logic done;
	logic hit;
	logic [31:0] read_next;

	assign trigger_addr[0] = video_loop_pkg::TRIGGER_ONE_ADDR;
	assign trigger_addr[1] = video_loop_pkg::TRIGGER_TWO_ADDR;
	assign status_addr[0] = video_loop_pkg::STATUS_ONE_ADDR;
	assign status_addr[1] = video_loop_pkg::STATUS_TWO_ADDR;

	// Analog flags are asynchronous to the bus clock
	flag_sync #(
		.WIDTH(6 * N)
	) u_flag_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.async_i({loop_locked_i, loop_bypassed_i, excess_jitter_flag_i,
			reference_lost_flag_i, recalibration_flag_i,
			controller_reset_complete_i}),
		.sync_o({locked_s, bypass_s, jitter_s, ref_lost_s, recal_s,
			reset_done_s})
	);

	// One wait state; the write lands on the edge that sees pready
	assign access = psel_i && penable_i;
	assign done = access && pready_o;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			pready_o <= 1'b0;
		else
			pready_o <= access && !pready_o;
	end

	// Address decode and read mux
	always_comb
	begin
		hit = 1'b0;
		read_next = video_loop_pkg::READ_RESET;
		for (int i = 0; i < N; i++)
		begin
			if (paddr_i == trigger_addr[i])
			begin
				hit = 1'b1;
				read_next[video_loop_pkg::BUSY_BIT] = busy[i];
			end
			if (paddr_i == status_addr[i])
			begin
				hit = 1'b1;
				read_next[video_loop_pkg::STATUS_W-1:0] = status_reg[i];
			end
		end
		if (paddr_i == video_loop_pkg::ATTEMPTS_ADDR)
		begin
			hit = 1'b1;
			read_next[video_loop_pkg::ATTEMPT_W-1:0] = attempts[0];
			read_next[video_loop_pkg::ATTEMPT_TWO_LSB +:
				video_loop_pkg::ATTEMPT_W] = attempts[1];
		end
	end

	// Read data and error captured as pready rises
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			prdata_o <= video_loop_pkg::READ_RESET;
			pslverr_o <= 1'b0;
		end
		else if (access && !pready_o)
		begin
			prdata_o <= pwrite_i ? video_loop_pkg::READ_RESET : read_next;
			pslverr_o <= !hit;
		end
		else
		begin
			pslverr_o <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_loop
			// Go is one-shot; it reads back as busy, never as stored
			assign go_pulse[g] = done && pwrite_i && pstrb_i[0] &&
				paddr_i == trigger_addr[g] &&
				pwdata_i[video_loop_pkg::GO_BIT];

			loop_sequencer u_seq (
				.clk_sys_i(clk_sys_i),
				.rst_b_i(rst_b_i),
				.go_i(go_pulse[g]),
				.locked_i(locked_s[g]),
				.restart_o(restart[g]),
				.busy_o(busy[g]),
				.attempts_o(attempts[g])
			);

			// Lock only shows once the sequence has settled, so a stale
			// lock from before a retry is masked only while the retry is busy
			always_ff @(posedge clk_sys_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
					status_reg[g] <= video_loop_pkg::STATUS_RESET;
				else
				begin
					status_reg[g][video_loop_pkg::BYPASS_BIT] <=
						bypass_s[g];
					status_reg[g][video_loop_pkg::JITTER_BIT] <=
						jitter_s[g];
					status_reg[g][4] <= 1'b0;
					status_reg[g][video_loop_pkg::REF_LOST_BIT] <=
						ref_lost_s[g];
					status_reg[g][video_loop_pkg::RECAL_BIT] <=
						recal_s[g] || busy[g];
					status_reg[g][video_loop_pkg::LOCK_BIT] <=
						locked_s[g] && !busy[g];
					status_reg[g][video_loop_pkg::RESET_DONE_BIT] <=
						reset_done_s[g];
				end
			end

			AST_NO_BYPASS_READS_ZERO: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				!bypass_s[g] ##1 !bypass_s[g] |->
				!status_reg[g][video_loop_pkg::BYPASS_BIT])
				else $error("Bypass flag set without bypass");

			AST_JITTER_FOLLOWS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				$rose(excess_jitter_flag_i[g]) ##1
				excess_jitter_flag_i[g] [*2] |=>
				status_reg[g][video_loop_pkg::JITTER_BIT])
				else $error("Jitter flag missed after three cycles");

			AST_REF_LOST_FOLLOWS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				status_reg[g][video_loop_pkg::REF_LOST_BIT] |->
				$past(ref_lost_s[g]))
				else $error("Reference lost flag without cause");

			AST_RECAL_WHILE_BUSY: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				go_pulse[g] |=> ##1
				status_reg[g][video_loop_pkg::RECAL_BIT] [*4])
				else $error("Recalibration flag low during restart");

			AST_LOCK_AFTER_SETTLE: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				status_reg[g][video_loop_pkg::LOCK_BIT] |->
				$past(locked_s[g]) && !$past(busy[g]))
				else $error("Lock shown while unlocked or busy");

			AST_NO_LOCK_DURING_RESTART: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				go_pulse[g] |=> ##1
				!status_reg[g][video_loop_pkg::LOCK_BIT] [*4])
				else $error("Stale lock shown during a retry");

			AST_RESET_DONE_FOLLOWS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				$rose(controller_reset_complete_i[g]) ##1
				controller_reset_complete_i[g] [*2] |=>
				status_reg[g][video_loop_pkg::RESET_DONE_BIT])
				else $error("Reset done flag missed");

			AST_JITTER_CLEARS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				!jitter_s[g] |=>
				!status_reg[g][video_loop_pkg::JITTER_BIT])
				else $error("Jitter flag stayed after jitter cleared");

			AST_REF_LOST_SETS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				ref_lost_s[g] |=>
				status_reg[g][video_loop_pkg::REF_LOST_BIT])
				else $error("Reference loss not flagged");

			AST_RECAL_SETS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				recal_s[g] |=>
				status_reg[g][video_loop_pkg::RECAL_BIT])
				else $error("Recalibration request not flagged");

			AST_LOCK_CLEARS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				!locked_s[g] |=>
				!status_reg[g][video_loop_pkg::LOCK_BIT])
				else $error("Lock shown after lock was lost");

			AST_RESET_DONE_CLEARS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				!reset_done_s[g] |=>
				!status_reg[g][video_loop_pkg::RESET_DONE_BIT])
				else $error("Reset done shown without controller done");

			AST_ATTEMPT_COUNTS: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				go_pulse[g] &&
				attempts[g] != video_loop_pkg::ATTEMPT_MAX |=>
				attempts[g] == $past(attempts[g]) + 5'h01)
				else $error("Go did not count an attempt");

			AST_RESTART_ONLY_AFTER_GO: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				$rose(loop_restart_o[g]) |->
				$past(go_pulse[g], 2))
				else $error("Restart pin rose without a go");

			AST_STATUS_READ_BACK: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				access && !pready_o && !pwrite_i &&
				paddr_i == status_addr[g] |=>
				prdata_o[video_loop_pkg::STATUS_W-1:0] ==
				$past(status_reg[g]))
				else $error("Status read did not return the flags");

			AST_BUSY_READ_BACK: assert property (
				@(posedge clk_sys_i) disable iff (!rst_b_i)
				access && !pready_o && !pwrite_i &&
				paddr_i == trigger_addr[g] |=>
				prdata_o[video_loop_pkg::BUSY_BIT] == $past(busy[g]))
				else $error("Trigger read did not return busy");
		end
	endgenerate

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			loop_restart_o <= 2'h0;
		else
			loop_restart_o <= restart;
	end

	AST_PREADY_ONE_CYCLE: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pready_o |=> !pready_o)
		else $error("Pready held for two cycles");

	AST_GO_REACHES_PIN: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		go_pulse[0] |=> ##1 loop_restart_o[0] [*4])
		else $error("Go did not reach restart pin");

	AST_UNMAPPED_ERRORS: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		access && !pready_o &&
		paddr_i != video_loop_pkg::TRIGGER_ONE_ADDR &&
		paddr_i != video_loop_pkg::STATUS_ONE_ADDR &&
		paddr_i != video_loop_pkg::TRIGGER_TWO_ADDR &&
		paddr_i != video_loop_pkg::STATUS_TWO_ADDR &&
		paddr_i != video_loop_pkg::ATTEMPTS_ADDR |=> pslverr_o)
		else $error("Unmapped access gave no error");

	AST_ERROR_WITH_READY: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		pslverr_o |-> pready_o)
		else $error("Error shown outside the answer cycle");

	AST_READY_AFTER_WAIT: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		access && !pready_o |=> pready_o)
		else $error("Access not answered after one wait state");

endmodule : video_loop_lock_ctrl
`default_nettype wire

// [dv/test_video_loop_lock_ctrl.sv]
// Self-checking bench for the video loop lock controller
`timescale 1ns/1ps
`default_nettype none
module test_video_loop_lock_ctrl;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic [31:0] rd_seen;
	logic pready;
	logic pslverr;
	logic [1:0] lk = 2'h0;
	logic [1:0] byp = 2'h0;
	logic [1:0] jit = 2'h0;
	logic [1:0] refl = 2'h0;
	logic [1:0] rec = 2'h0;
	logic [1:0] done = 2'h0;
	logic [1:0] restart;
	logic [32:0] expq[$];
	logic [31:0] att = 32'h0000_0000;
	logic [11:0] ta;
	logic [11:0] sa;
	int n_mismatch = 0;
	int n_tests = 0;

	video_loop_lock_ctrl u_video_loop_lock_ctrl (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.paddr_i(paddr),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.pwdata_i(pwdata),
		.pstrb_i(pstrb),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.loop_locked_i(lk),
		.loop_bypassed_i(byp),
		.excess_jitter_flag_i(jit),
		.reference_lost_flag_i(refl),
		.recalibration_flag_i(rec),
		.controller_reset_complete_i(done),
		.loop_restart_o(restart)
	);

	always #10 clk_sys_i = ~clk_sys_i;

	task wrap_up;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] stat(input logic [5:0] f);
		// Order: bypass, jitter, ref lost, recal, lock, reset done
		return {25'h0, f[5], f[4], 1'b0, f[3:0]};
	endfunction : stat

	// Every access is compared as it completes; writes by error only
	assign rd_seen = pwrite ? 32'h0000_0000 : prdata;

	always @(posedge clk_sys_i)
		if (psel && penable && pready === 1'b1)
			check({pslverr, rd_seen}, expq.pop_front());

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [32:0] e);
		int n;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		expq.push_back(e);
		@(posedge clk_sys_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'hF, {1'b0, e});
	endtask : rd

	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s, 33'h0_0000_0000);
	endtask : wr

	// Counts restart cycles over a window wider than the pulse
	task pulse(input int k, input int exp);
		int c;
		c = 0;
		repeat (10)
		begin
			@(posedge clk_sys_i);
			if (restart[k] === 1'b1)
				c++;
		end
		check(33'(c), 33'(exp));
	endtask : pulse

	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		wrap_up;
	end

	initial
	begin
		void'($urandom(32'haaca));
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rd(video_loop_pkg::TRIGGER_ONE_ADDR, 32'h0000_0000);
		rd(video_loop_pkg::STATUS_ONE_ADDR, 32'h0000_0000);
		rd(video_loop_pkg::TRIGGER_TWO_ADDR, 32'h0000_0000);
		rd(video_loop_pkg::STATUS_TWO_ADDR, 32'h0000_0000);
		rd(video_loop_pkg::ATTEMPTS_ADDR, 32'h0000_0000);
		done <= 2'h3;
		for (int k = 0; k < 2; k++)
		begin
			ta = k ? video_loop_pkg::TRIGGER_TWO_ADDR
				: video_loop_pkg::TRIGGER_ONE_ADDR;
			sa = k ? video_loop_pkg::STATUS_TWO_ADDR
				: video_loop_pkg::STATUS_ONE_ADDR;
			// First attempt fails to lock, so a retry follows
			// Loop setup stays fixed from before this go through retries
			wr(ta, 32'h0000_0001, 4'hF);
			pulse(k, 4);
			rd(ta, 32'h0000_0001);
			rd(sa, stat(6'h05));
			wr(ta, 32'h0000_0001, 4'hF);
			pulse(k, 4);
			att = att + (32'h0000_0002 <<
				(k * video_loop_pkg::ATTEMPT_TWO_LSB));
			lk[k] <= 1'b1;
			repeat (8) @(posedge clk_sys_i);
			rd(ta, 32'h0000_0000);
			rd(sa, stat(6'h03));
			// Go ignored without byte strobe or without bit 0
			wr(ta, 32'h0000_0001, 4'hE);
			pulse(k, 0);
			wr(ta, 32'h0000_0002, 4'hF);
			pulse(k, 0);
			rd(video_loop_pkg::ATTEMPTS_ADDR, att);
		end
		// Loop one retried up to twenty attempts, below the count's saturation at 31
		repeat (18)
			wr(video_loop_pkg::TRIGGER_ONE_ADDR, 32'h0000_0001, 4'hF);
		rd(video_loop_pkg::ATTEMPTS_ADDR, 32'h0000_0214);
		repeat (8) @(posedge clk_sys_i);
		repeat (8)
		begin
			@(posedge clk_sys_i);
			byp <= 2'($urandom);
			jit <= 2'($urandom);
			refl <= 2'($urandom);
			rec <= 2'($urandom);
			lk <= 2'($urandom);
			done <= 2'($urandom);
			wr(video_loop_pkg::STATUS_ONE_ADDR, 32'hFFFF_FFFF, 4'hF);
			repeat (4) @(posedge clk_sys_i);
			rd(video_loop_pkg::STATUS_ONE_ADDR, stat({byp[0], jit[0], refl[0],
				rec[0], lk[0], done[0]}));
			rd(video_loop_pkg::STATUS_TWO_ADDR, stat({byp[1], jit[1], refl[1],
				rec[1], lk[1], done[1]}));
		end
		apb(1'b0, 12'h014, 32'h0000_0000, 4'hF, 33'h1_0000_0000);
		repeat (2) @(posedge clk_sys_i);
		wrap_up;
	end
endmodule : test_video_loop_lock_ctrl
`default_nettype wire
